// >>> rtl/sfl_dev.sv
// Device end of the serial flash link: command parser, two page buffers, read responses.
// Assumes the host keeps the link rules; user side runs on clk_i, link side on the link clock.
`timescale 1ns/10ps
module sfl_dev #(
  parameter bit PRESET_256 = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  sfl_link_if.dev          lk,
  output logic             prog_evt_o,
  output logic             prog_buf2_o,
  output logic [10:0]      prog_page_o,
  output logic             page256_o
);
  import sfl_pkg::*;

  typedef struct packed {
    sfl_phase_t  ph;
    logic [2:0]  bc;
    logic [2:0]  left;
    logic [7:0]  op;
    logic [7:0]  sh;
    logic [23:0] addr;
    logic [8:0]  ptr;
  } sfl_dst_t;

  typedef struct packed {
    logic [2:0]  tog_s;
    logic        p256_s1;
    logic        p256_s2;
    logic        evt;
    logic        buf2;
    logic [10:0] page;
  } sfl_dsys_t;

  sfl_dst_t    s;
  sfl_dst_t    next_s;
  sfl_dsys_t   u;
  sfl_dsys_t   next_u;
  logic [7:0]  mem [0:1][0:511];
  logic [7:0]  sh_n;
  logic [8:0]  psize;
  logic        done;
  logic        we;
  logic        evt;
  logic        cfg_hit;
  logic        frame_rst;
  logic        cfg256;
  logic        prog_tog;
  logic        prog_b2;
  logic [10:0] prog_pg;
  logic        so_q;
  logic        oe_n_q;
  logic [7:0]  tx_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Parser, clocked on the rising link edge
  assign frame_rst = lk.cs_n | ~lk.reset_n;
  assign psize     = cfg256 ? PAGE_SMALL : PAGE_BIG;
  assign sh_n      = {s.sh[6:0], lk.mosi};
  assign done      = (s.bc == 3'd7);

  always_comb
  begin
    next_s   = s;
    next_s.sh = sh_n;
    next_s.bc = s.bc + 3'd1;
    we       = 1'b0;
    evt      = 1'b0;
    cfg_hit  = 1'b0;
    case (s.ph)
      PH_OP:
      begin
        if (done)
        begin
          next_s.op   = sh_n;
          next_s.left = sfl_lead(sh_n);
          next_s.ptr  = '0;
          next_s.ph   = (sfl_lead(sh_n) == 3'd0) ? PH_DATA : PH_LEAD;
        end
      end
      PH_LEAD:
      begin
        if (done)
        begin
          // Trailing dummy bytes must not disturb the captured address
          if (s.left > sfl_lead(s.op) - 3'd3)
            next_s.addr = {s.addr[15:0], sh_n};
          next_s.left = s.left - 3'd1;
          if (s.left == 3'd1)
          begin
            next_s.ph  = PH_DATA;
            next_s.ptr = cfg256 ? {1'b0, next_s.addr[7:0]} : next_s.addr[8:0];
            evt        = sfl_is_prog(s.op);
            cfg_hit    = (s.op == OP_CFG_PAGE) && (next_s.addr == CFG_KEY);
          end
        end
      end
      PH_DATA:
      begin
        if (done)
        begin
          we         = sfl_is_wr(s.op);
          next_s.ptr = (s.ptr >= psize - 9'd1) ? 9'd0 : s.ptr + 9'd1;
        end
      end
      default: next_s.ph = PH_OP;
    endcase
  end

  always_ff @(posedge lk.sck or posedge frame_rst)
  begin
    if (frame_rst)
      s <= '{ph: PH_OP, default: '0};
    else
      s <= next_s;
  end

  always_ff @(posedge lk.sck)
  begin
    if (we)
      mem[sfl_buf2(s.op)][s.ptr] <= sh_n;
  end

  // Settings and program events survive frame ends, so only the reset pin clears them
  always_ff @(posedge lk.sck or negedge lk.reset_n)
  begin
    if (!lk.reset_n)
    begin
      cfg256   <= PRESET_256;
      prog_tog <= 1'b0;
      prog_b2  <= 1'b0;
      prog_pg  <= '0;
    end
    else
    begin
      if (cfg_hit)
        cfg256 <= 1'b1;
      if (evt)
      begin
        prog_tog <= ~prog_tog;
        prog_b2  <= sfl_buf2(s.op);
        prog_pg  <= cfg256 ? next_s.addr[18:8] : next_s.addr[19:9];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Response, launched on the falling link edge
  always_comb
  begin
    case (s.op)
      OP_RD_STAT: tx_byte = {1'b1, 1'b0, STAT_DENSITY, 1'b0, cfg256};
      OP_RD_ID:
        case (s.ptr)
          9'd0:    tx_byte = ID_MFR;
          9'd1:    tx_byte = ID_DEV1;
          9'd2:    tx_byte = ID_DEV2;
          default: tx_byte = 8'h00;
        endcase
      OP_RD_PROT, OP_RD_LOCK: tx_byte = 8'h00;
      OP_RD_SEC: tx_byte = (s.ptr < SEC_USER_LEN) ? 8'hff : {1'b0, s.ptr[6:0]};
      OP_RD_BUF1, OP_RD_BUF2: tx_byte = mem[sfl_buf2(s.op)][s.ptr];
      default: tx_byte = mem[0][s.ptr];
    endcase
  end

  // The bit leaves on the falling edge, so it is stable through the whole low phase
  always_ff @(negedge lk.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      so_q   <= tx_byte[~s.bc];
      oe_n_q <= ~((s.ph == PH_DATA) && sfl_is_rd(s.op));
    end
  end

  assign lk.miso      = so_q;
  assign lk.miso_oe_n = oe_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing to the user clock: toggle for events, two flops for the page-size level
  always_comb
  begin
    next_u         = u;
    next_u.tog_s   = {u.tog_s[1:0], prog_tog};
    next_u.p256_s1 = cfg256;
    next_u.p256_s2 = u.p256_s1;
    next_u.evt     = u.tog_s[2] ^ u.tog_s[1];
    if (u.tog_s[2] ^ u.tog_s[1])
    begin
      // Page and buffer were set on the same link edge as the toggle and stay put until the next event
      next_u.buf2 = prog_b2;
      next_u.page = prog_pg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      u <= '0;
    else
      u <= next_u;
  end

  assign prog_evt_o  = u.evt;
  assign prog_buf2_o = u.buf2;
  assign prog_page_o = u.page;
  assign page256_o   = u.p256_s2;

endmodule : sfl_dev

// >>> rtl/sfl_host.sv
// Host end of the serial flash link and its receive FIFO.
// Assumes one command at a time from the user side; the link clock is made here by division.
`timescale 1ns/10ps
module sfl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]   cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic          vld;
    logic          rdy;
  } sfl_fst_t;

  sfl_fst_t     f;
  sfl_fst_t     next_f;
  logic [W-1:0] mem [0:DEPTH-1];
  logic         push;
  logic         pop;

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("sfl_fifo: DEPTH must be a power of two");
  end

  assign push = in_valid_i && f.rdy;
  assign pop  = out_ready_i && f.vld;

  always_comb
  begin
    next_f     = f;
    next_f.wp  = push ? f.wp + 1'b1 : f.wp;
    next_f.rp  = pop ? f.rp + 1'b1 : f.rp;
    next_f.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Flags are registered so both handshake outputs come straight from flops
    next_f.vld = (next_f.cnt != '0);
    next_f.rdy = (next_f.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      f <= '{rdy: 1'b1, default: '0};
    else
      f <= next_f;
    if (push)
      mem[f.wp] <= in_data_i;
  end

  assign in_ready_o  = f.rdy;
  assign out_valid_o = f.vld;
  assign out_data_o  = mem[f.rp];
endmodule : sfl_fifo

////////////////////////////////////////////////////////////////////////////////
module sfl_host #(
  parameter bit HOST_PAGE256 = 1'b0,
  parameter bit CPOL         = 1'b0,
  parameter int HALF         = sfl_pkg::SCK_HALF,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  sfl_link_if.host         lk,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_op_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [9:0]  cmd_len_i,
  output logic             cmd_ready_o,
  input  wire logic        wr_valid_i,
  input  wire logic [7:0]  wr_data_i,
  output logic             wr_ready_o,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  input  wire logic        rd_ready_i
);
  import sfl_pkg::*;

  typedef enum logic [4:0] {H_RST = 5'h01, H_REC = 5'h02, H_IDLE = 5'h04,
                            H_SHIFT = 5'h08, H_GAP = 5'h10} sfl_hstate_t;

  typedef struct packed {
    sfl_hstate_t st;
    logic [11:0] cnt;
    logic        sck;
    logic        cs_n;
    logic        rstn;
    logic [7:0]  tx;
    logic [13:0] k;
    logic [13:0] total;
    logic [13:0] nlead;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        rd;
    logic [7:0]  rx;
    logic        push;
    logic [7:0]  push_data;
    logic        want;
    logic        wfull;
    logic [7:0]  wbuf;
    logic        cmd_ready;
    logic        rw_pend;
    logic [10:0] rw_ptr;
    logic [1:0]  miso_s;
    logic        mosi;
  } sfl_hst_t;

  sfl_hst_t    h;
  sfl_hst_t    next_h;
  logic        fifo_ready;
  logic        tick;
  logic        stall;
  logic [13:0] nk;
  logic [13:0] rk;
  logic [10:0] bidx;
  logic [7:0]  st_op;
  logic [23:0] st_addr;
  logic [9:0]  st_len;
  logic        start;

  initial
  begin
    if (HALF < SCK_HALF || HALF > 4000)
      $error("sfl_host: HALF too small for the link or too large for the counter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign nk    = h.k + 14'd1;
  assign rk    = h.k - h.nlead;
  assign bidx  = nk[13:3];
  // The rise that ends the last byte needs no new byte, so it never waits for one
  assign stall = (h.push && !fifo_ready)
               || (!h.sck && nk < h.total && nk[2:0] == 3'd0 && nk >= h.nlead
                   && !h.rd && !h.wfull);
  assign tick  = (h.cnt == 12'(HALF - 1)) && !stall;
  // Owed page rewrites go ahead of user commands
  assign start   = (h.st == H_IDLE) && (h.rw_pend || (cmd_valid_i && h.cmd_ready));
  assign st_op   = h.rw_pend ? OP_REWRITE1 : cmd_op_i;
  assign st_addr = h.rw_pend ? (HOST_PAGE256 ? {5'd0, h.rw_ptr, 8'd0}
                                             : {4'd0, h.rw_ptr, 9'd0}) : cmd_addr_i;
  assign st_len  = h.rw_pend ? 10'd0 : cmd_len_i;

  always_comb
  begin
    next_h        = h;
    next_h.miso_s = {h.miso_s[0], lk.miso_line};
    // mosi moves one clock after the rise, so the capture at that rise never races the change
    next_h.mosi   = h.tx[7];
    next_h.cnt    = h.cnt + 12'd1;
    if (h.push && fifo_ready)
      next_h.push = 1'b0;
    next_h.want = (h.st == H_SHIFT) && !h.rd && !h.wfull && !(wr_valid_i && h.want);
    if (wr_valid_i && h.want)
    begin
      next_h.wfull = 1'b1;
      next_h.wbuf  = wr_data_i;
    end
    case (h.st)
      H_RST:
      begin
        next_h.cs_n = 1'b1;
        next_h.rstn = 1'b0;
        if (h.cnt == 12'(RST_CYC - 1))
        begin
          next_h.st  = H_REC;
          next_h.cnt = '0;
          next_h.rstn = 1'b1;
        end
      end
      H_REC, H_GAP:
      begin
        if (h.cnt >= 12'(h.st == H_REC ? REC_CYC - 1 : CSHI_CYC - 1))
          next_h.st = H_IDLE;
      end
      H_IDLE:
      begin
        if (start)
        begin
          next_h.st    = H_SHIFT;
          next_h.cnt   = '0;
          next_h.cs_n  = 1'b0;
          next_h.op    = st_op;
          next_h.addr  = st_addr;
          next_h.rd    = sfl_is_rd(st_op);
          next_h.tx    = st_op;
          next_h.k     = '0;
          next_h.mosi  = st_op[7];
          next_h.nlead = {8'd0, sfl_lead(st_op), 3'd0} + 14'd8;
          next_h.total = {8'd0, sfl_lead(st_op), 3'd0} + 14'd8 + {1'b0, st_len, 3'd0};
        end
      end
      H_SHIFT:
      begin
        if (stall)
          next_h.cnt = h.cnt;
        else if (tick)
        begin
          next_h.cnt = '0;
          if (!h.sck)
          begin
            if (h.k < h.total)
            begin
              next_h.sck = 1'b1;
              next_h.k   = nk;
              // Drive the next bit on the rising edge: the device takes it one full period on
              if (nk[2:0] != 3'd0)
                next_h.tx = {h.tx[6:0], 1'b0};
              else if (bidx >= 11'd1 && bidx <= 11'd3 && nk < h.nlead)
                next_h.tx = h.addr[8'(23 - 8 * (bidx - 11'd1)) -: 8];
              else if (nk < h.nlead)
                next_h.tx = 8'h00;
              else
              begin
                next_h.tx    = h.wbuf;
                next_h.wfull = 1'b0;
              end
            end
            else if (CPOL)
            begin
              next_h.sck = 1'b1;
              next_h.st  = H_GAP;
            end
            else
              next_h.st = H_GAP;
          end
          else if (h.k == h.total && CPOL && !h.rd)
            next_h.st = H_GAP;
          else
          begin
            next_h.sck = 1'b0;
            // Sample on the falling edge after the launching one: a whole period of margin
            if (h.rd && h.k > h.nlead)
            begin
              next_h.rx = {h.rx[6:0], h.miso_s[1]};
              if (rk[2:0] == 3'd0)
              begin
                next_h.push      = 1'b1;
                next_h.push_data = {h.rx[6:0], h.miso_s[1]};
              end
            end
          end
          if (next_h.st == H_GAP)
          begin
            next_h.cs_n = 1'b1;
            next_h.cnt  = '0;
            // Each program other than OP_REWRITE1 earns one page rewrite, far inside the sector wear limit
            if (h.op == OP_REWRITE1)
            begin
              next_h.rw_pend = 1'b0;
              next_h.rw_ptr  = h.rw_ptr + 11'd1;
            end
            else if (sfl_is_prog(h.op))
              next_h.rw_pend = 1'b1;
          end
        end
      end
      default: next_h.st = H_RST;
    endcase
    next_h.cmd_ready = (next_h.st == H_IDLE) && !next_h.rw_pend && !start;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      h <= '{st: H_RST, cs_n: 1'b1, sck: CPOL, default: '0};
    else
      h <= next_h;
  end

  assign lk.sck      = h.sck;
  assign lk.cs_n     = h.cs_n;
  assign lk.mosi     = h.mosi;
  assign lk.reset_n  = h.rstn;
  assign cmd_ready_o = h.cmd_ready;
  assign wr_ready_o  = h.want;

  sfl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (h.push),
    .in_data_i   (h.push_data),
    .in_ready_o  (fifo_ready),
    .out_valid_o (rd_valid_o),
    .out_data_o  (rd_data_o),
    .out_ready_i (rd_ready_i)
  );

endmodule : sfl_host

// >>> rtl/sfl_link_if.sv
// Serial link between host and flash device.
// Assumes the bench or system joins one host end and one device end.
`timescale 1ns/10ps
interface sfl_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic reset_n;
  logic miso;
  logic miso_oe_n;
  wire  miso_line;

  // No pull-up here: a released line shows the inverse of the last bit, so a late sample shows up
  assign miso_line = miso_oe_n ? ~miso : miso;

  modport dev  (input sck, input cs_n, input mosi, input reset_n, output miso, output miso_oe_n);
  modport host (output sck, output cs_n, output mosi, output reset_n, input miso_line);
endinterface : sfl_link_if

// >>> rtl/sfl_pkg.sv
// Shared constants, types and command decoding for the serial flash link.
// Assumes a 200 MHz system clock on the host end; the device parser runs on the link clock, its user side on clk_i.
package sfl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] OP_RD_ARRAY     = 8'h0b;
  localparam logic [7:0] OP_RD_ARRAY_LEG = 8'he8;
  localparam logic [7:0] OP_RD_ARRAY_LF  = 8'h03;
  localparam logic [7:0] OP_RD_BUF1      = 8'hd1;
  localparam logic [7:0] OP_RD_BUF2      = 8'hd3;
  localparam logic [7:0] OP_RD_PROT      = 8'h32;
  localparam logic [7:0] OP_RD_LOCK      = 8'h35;
  localparam logic [7:0] OP_RD_SEC       = 8'h77;
  localparam logic [7:0] OP_RD_STAT      = 8'hd7;
  localparam logic [7:0] OP_RD_ID        = 8'h9f;
  localparam logic [7:0] OP_WR_BUF1      = 8'h84;
  localparam logic [7:0] OP_WR_BUF2      = 8'h87;
  localparam logic [7:0] OP_PROG_VIA1    = 8'h82;
  localparam logic [7:0] OP_PROG_VIA2    = 8'h85;
  localparam logic [7:0] OP_BUF1_PROG    = 8'h83;
  localparam logic [7:0] OP_BUF2_PROG    = 8'h86;
  localparam logic [7:0] OP_REWRITE1     = 8'h58;
  localparam logic [7:0] OP_REWRITE2     = 8'h59;
  localparam logic [7:0] OP_CFG_PAGE     = 8'h3d;
  localparam logic [23:0] CFG_KEY        = 24'h5aa501;

  ////////////////////////////////////////////////////////////////////////////////
  // Page geometry, status and identity (identity values are arbitrary)
  localparam logic [8:0] PAGE_BIG     = 9'h108;
  localparam logic [8:0] PAGE_SMALL   = 9'h100;
  localparam logic [3:0] STAT_DENSITY = 4'h3;
  localparam logic [7:0] ID_MFR       = 8'h5e;
  localparam logic [7:0] ID_DEV1      = 8'h11;
  localparam logic [7:0] ID_DEV2      = 8'h00;
  localparam logic [8:0] SEC_USER_LEN = 9'h040;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ     = 200;
  localparam int SCK_MAX_MHZ = 66;
  localparam int SCK_HALF    = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int T_RST_US    = 10;
  localparam int RST_CYC     = T_RST_US * CLK_MHZ;
  localparam int T_REC_US    = 1;
  localparam int REC_CYC     = T_REC_US * CLK_MHZ;
  localparam int T_CSHI_NS   = 50;
  localparam int CSHI_CYC    = (T_CSHI_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {PH_OP = 3'b001, PH_LEAD = 3'b010, PH_DATA = 3'b100} sfl_phase_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding used by both ends (sfl_is_wr and sfl_buf2 by the device end only)
  function automatic logic [2:0] sfl_lead(input logic [7:0] op);
    case (op)
      OP_RD_ARRAY:            sfl_lead = 3'd4;
      OP_RD_ARRAY_LEG:        sfl_lead = 3'd7;
      OP_RD_STAT, OP_RD_ID:   sfl_lead = 3'd0;
      default:                sfl_lead = 3'd3;
    endcase
  endfunction : sfl_lead

  function automatic logic sfl_is_rd(input logic [7:0] op);
    sfl_is_rd = op inside {OP_RD_ARRAY, OP_RD_ARRAY_LEG, OP_RD_ARRAY_LF, OP_RD_BUF1, OP_RD_BUF2,
                           OP_RD_PROT, OP_RD_LOCK, OP_RD_SEC, OP_RD_STAT, OP_RD_ID};
  endfunction : sfl_is_rd

  function automatic logic sfl_is_wr(input logic [7:0] op);
    sfl_is_wr = op inside {OP_WR_BUF1, OP_WR_BUF2, OP_PROG_VIA1, OP_PROG_VIA2};
  endfunction : sfl_is_wr

  function automatic logic sfl_is_prog(input logic [7:0] op);
    sfl_is_prog = op inside {OP_PROG_VIA1, OP_PROG_VIA2, OP_BUF1_PROG, OP_BUF2_PROG,
                             OP_REWRITE1, OP_REWRITE2};
  endfunction : sfl_is_prog

  function automatic logic sfl_buf2(input logic [7:0] op);
    sfl_buf2 = op inside {OP_WR_BUF2, OP_PROG_VIA2, OP_BUF2_PROG, OP_RD_BUF2, OP_REWRITE2};
  endfunction : sfl_buf2

endpackage : sfl_pkg

// >>> tb/sfl_link_asserts.sv
// Checker for the serial link wires between host and device ends.
// Assumes the link is sampled on the 200 MHz host clock.
`timescale 1ns/10ps
module sfl_link_asserts #(
  parameter bit CPOL = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic reset_n,
  input wire logic miso,
  input wire logic miso_oe_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_miso_fall; !cs_n && $past(!cs_n) && $changed(miso) |-> $fell(sck); endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off a falling edge");
  property p_oe_fall; $fell(miso_oe_n) |-> $fell(sck) && !cs_n; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("output enabled off a falling edge");
  property p_oe_cs; cs_n |-> miso_oe_n; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("miso driven while deselected");
  property p_mosi_rise;
    !cs_n && $past(!cs_n) && $changed(mosi) |-> $past(sck) && !$past(sck, 2); endproperty
  a_mosi_rise: assert property (p_mosi_rise) else $error("mosi moved off a rising edge");
  property p_cs_fall; $fell(cs_n) |-> sck == CPOL && $stable(sck); endproperty
  a_cs_fall: assert property (p_cs_fall) else $error("clock not idle at select");
  property p_sck_idle; cs_n && $past(cs_n) |-> sck == CPOL; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock moved while deselected");
  property p_half; $changed(sck) |=> $stable(sck); endproperty
  a_half: assert property (p_half) else $error("clock phase too short");
  property p_rst_cs; !reset_n |-> cs_n; endproperty
  a_rst_cs: assert property (p_rst_cs) else $error("select low during device reset");
  property p_rel_cs; $rose(reset_n) |-> cs_n && $past(cs_n); endproperty
  a_rel_cs: assert property (p_rel_cs) else $error("select low at reset release");
endmodule : sfl_link_asserts

// >>> tb/tb.sv
// Bench joining host and device ends: command reads, buffer writes, programs, FIFO stall.
// Assumes the host end divides clk_i to make the link clock.
`timescale 1ns/10ps
module tb;
  import sfl_pkg::*;
  localparam logic [7:0] DAT [4] = '{8'ha5, 8'h3c, 8'h01, 8'h80};
  localparam logic [7:0] RDS [4] = '{OP_RD_ARRAY, OP_RD_ARRAY_LEG, OP_RD_ARRAY_LF, OP_RD_BUF1};
  logic        clk_i       = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  cmd_op_i    = 8'h00;
  logic [23:0] cmd_addr_i  = 24'h000000;
  logic [9:0]  cmd_len_i   = 10'h000;
  logic        wr_valid_i  = 1'b0;
  logic [7:0]  wr_data_i   = 8'h00;
  logic        rd_ready_i  = 1'b0;
  logic        cmd_ready_o, wr_ready_o, rd_valid_o, prog_evt_o, prog_buf2_o, page256_o;
  logic [7:0]  rd_data_o;
  logic [10:0] prog_page_o;
  logic [11:0] got [32];
  logic [11:0] ev [4];
  int          n_fail = 0;
  int          comparisons = 0;
  int          n_ev = 0;
  sfl_link_if lk ();
  sfl_host u_sfl_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lk(lk.host),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o), .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i));
  sfl_dev u_sfl_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .lk(lk.dev),
    .prog_evt_o(prog_evt_o), .prog_buf2_o(prog_buf2_o), .prog_page_o(prog_page_o),
    .page256_o(page256_o));
  sfl_link_asserts u_sfl_link_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck(lk.sck),
    .cs_n(lk.cs_n), .mosi(lk.mosi), .reset_n(lk.reset_n), .miso(lk.miso),
    .miso_oe_n(lk.miso_oe_n));
  always #2.5 clk_i = ~clk_i;
  // Log the first four program events as {buffer 2, page}
  always @(posedge clk_i)
    if (prog_evt_o === 1'b1 && n_ev < 4)
    begin
      ev[n_ev] <= {prog_buf2_o, prog_page_o};
      n_ev <= n_ev + 1;
    end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [9:0] n);
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_len_i <= n;
    cmd_valid_i <= 1'b1;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask : cmd
  task automatic pop(input int n);
    rd_ready_i <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      do @(posedge clk_i); while (rd_valid_o !== 1'b1);
      got[i] = {4'h0, rd_data_o};
    end
    rd_ready_i <= 1'b0;
  endtask : pop
  task automatic rd(input logic [7:0] op, input int n);
    cmd(op, 24'h000000, n[9:0]);
    pop(n);
  endtask : rd
  task automatic test_done;
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(OP_RD_ID, 3);
    check("id mfr", {4'h0, ID_MFR}, got[0]);
    check("id dev1", {4'h0, ID_DEV1}, got[1]);
    check("id dev2", {4'h0, ID_DEV2}, got[2]);
    rd(OP_RD_STAT, 1);
    check("status", {4'h0, 2'b10, STAT_DENSITY, 2'b00}, got[0]);
    cmd(OP_WR_BUF1, 24'h000000, 10'h004);
    for (int i = 0; i < 4; i++)
    begin
      wr_data_i <= DAT[i];
      wr_valid_i <= 1'b1;
      do @(posedge clk_i); while (wr_ready_o !== 1'b1);
    end
    wr_valid_i <= 1'b0;
    foreach (RDS[k])
    begin
      rd(RDS[k], 4);
      for (int i = 0; i < 4; i++) check("read data", {4'h0, DAT[i]}, got[i]);
    end
    rd(OP_RD_PROT, 2);
    check("protection", 12'h000, got[1]);
    rd(OP_RD_LOCK, 2);
    check("lockdown", 12'h000, got[1]);
    cmd(OP_BUF1_PROG, 24'h000600, 10'h000);
    cmd(OP_BUF2_PROG, 24'h000e00, 10'h000);
    rd(OP_RD_STAT, 1);
    check("events", 12'h004, n_ev[11:0]);
    check("event 0", 12'h003, ev[0]);
    check("event 1", 12'h000, ev[1]);
    check("event 2", 12'h807, ev[2]);
    check("event 3", 12'h001, ev[3]);
    // Twenty bytes overflow the 16-word FIFO, so the frame must stall
    cmd(OP_RD_SEC, 24'h000000, 10'h014);
    repeat (1500) @(posedge clk_i);
    check("stalled select", 12'h000, {11'h000, lk.cs_n});
    check("fifo valid", 12'h001, {11'h000, rd_valid_o});
    pop(20);
    for (int i = 0; i < 20; i++) check("security", 12'h0ff, got[i]);
    repeat (2) @(posedge clk_i);
    check("fifo empty", 12'h000, {11'h000, rd_valid_o});
    cmd(OP_CFG_PAGE, CFG_KEY, 10'h000);
    rd(OP_RD_STAT, 1);
    check("status 256", {4'h0, 2'b10, STAT_DENSITY, 2'b01}, got[0]);
    check("page256", 12'h001, {11'h000, page256_o});
    test_done;
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    test_done;
  end
endmodule : tb
